// ### verilog/pinirq_ctrl.sv
`timescale 1ns/1ps
module pinirq_ctrl (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  // wishbone classic slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // pins, read as inputs whatever their direction
  input wire logic ext_irq_pin_i, // external interrupt pin level
  input wire logic [5:0] change_inputs_i, // pin-change inputs
  // core side
  input wire logic global_irq_en_i, // global enable from core status
  input wire logic io_clk_run_i, // high while the I/O clock runs
  input wire logic sleeping_i, // core is asleep
  input wire logic core_reset_i, // any reset source active
  input wire logic [6:0] internal_req_i, // timer..converter requests
  input wire logic irq_taken_i, // core entering vector on irq_vec_o
  output logic irq_req_o, // dispatch request to core
  output logic [3:0] irq_vec_o, // vector word address
  output logic wake_o, // wake pulse for sleeping core
  output logic [3:0] fetch_addr_o // vector word to fetch from
);
  localparam int NS = pinirq_pkg::NUM_SOURCES;

  // the vector field is four bits wide and the internal request
  // port is seven bits: any other source count cannot be served
  if (NS != 9) begin : g_bad_ns
    $error("pinirq_ctrl: source count must be nine");
  end

  logic [1:0] sense_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_flag_r;
  logic [5:0] change_mask_r;
  logic pin_s_r;
  logic pin_d_r;
  logic [5:0] chg_d_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic irq_req_r;
  logic [3:0] irq_vec_r;
  logic wake_r;
  logic [3:0] fetch_r;

  // register write decode used by several processes
  function automatic logic wr_hit(input logic [3:0] ofs);
    return wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_r &&
      wb_sel_i[0] && (wb_adr_i == ofs);
  endfunction

  // vector entry on the given word clears that source's flag
  function automatic logic taken_is(input logic [3:0] v);
    return irq_taken_i && (irq_vec_r == v);
  endfunction

  // only the ext and change bits exist in the mask and flag words
  function automatic logic [7:0] rd_keep(input logic [3:0] ofs);
    if (ofs == pinirq_pkg::IRQ_MASK_OFS ||
        ofs == pinirq_pkg::IRQ_FLAG_OFS) begin
      return pinirq_pkg::IRQ_BITS_MASK;
    end
    return 8'hFF;
  endfunction

  // a fresh request: strobe seen and not yet answered
  logic bus_new;
  assign bus_new = wb_cyc_i && wb_stb_i && !wb_ack_r;

  // pin sample then delay: edges compare two sampled values
  // when the I/O clock stops both stages freeze, so a change made
  // meanwhile shows up as one edge once the clock runs again
  // sample before edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s_r <= 1'b1;
      pin_d_r <= 1'b1;
    end else if (io_clk_run_i) begin
      pin_s_r <= ext_irq_pin_i;
      pin_d_r <= pin_s_r;
    end
  end

  // edge events; only valid while the I/O clock runs
  logic rise_ev;
  logic fall_ev;
  logic ext_edge_ev;
  assign rise_ev = io_clk_run_i && pin_s_r && !pin_d_r;
  assign fall_ev = io_clk_run_i && !pin_s_r && pin_d_r;

  pinirq_pkg::pinirq_sense_type sense_mode;
  assign sense_mode = pinirq_pkg::pinirq_sense_type'(sense_r);
  always_comb begin
    unique case (sense_mode)
      pinirq_pkg::PINIRQ_LOW: ext_edge_ev = 1'b0;
      pinirq_pkg::PINIRQ_ANY: ext_edge_ev = rise_ev || fall_ev;
      pinirq_pkg::PINIRQ_FALL: ext_edge_ev = fall_ev;
      pinirq_pkg::PINIRQ_RISE: ext_edge_ev = rise_ev;
    endcase
  end

  // level request follows the raw pin, no clock needed
  logic level_mode;
  logic ext_level_req;
  assign level_mode = (sense_mode == pinirq_pkg::PINIRQ_LOW);
  assign ext_level_req = level_mode && !ext_irq_pin_i;

  // change detection compares raw pins with last seen value;
  // the compare itself is combinational so it needs no clock
  logic [5:0] chg_toggle;
  logic chg_ev;
  assign chg_toggle = (change_inputs_i ^ chg_d_r) & change_mask_r;
  assign chg_ev = |chg_toggle;

  // last seen change inputs, updated as the system clock runs
  // a toggle shorter than one clock may miss the flag and the registered wake alike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_d_r <= 6'h00;
    end else begin
      chg_d_r <= change_inputs_i;
    end
  end

  // sense control register
  // only the two sense bits are stored; the rest read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_r <= pinirq_pkg::SENSE_CTRL_RST[1:0];
    end else if (wr_hit(pinirq_pkg::SENSE_CTRL_OFS)) begin
      sense_r <= wb_dat_i[pinirq_pkg::SENSE_HI_POS:
                          pinirq_pkg::SENSE_LO_POS];
    end
  end

  // interrupt mask register, bit 1 = external, bit 0 = change
  // other written bits are reserved and ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= pinirq_pkg::IRQ_MASK_RST[6:5];
    end else if (wr_hit(pinirq_pkg::IRQ_MASK_OFS)) begin
      irq_mask_r <= {wb_dat_i[pinirq_pkg::EXT_BIT_POS],
                     wb_dat_i[pinirq_pkg::CHG_BIT_POS]};
    end
  end

  // bits above five do not exist and are dropped on write
  // per-pin masks reset zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_mask_r <= pinirq_pkg::CHANGE_MASK_RST;
    end else if (wr_hit(pinirq_pkg::CHANGE_MASK_OFS)) begin
      change_mask_r <= wb_dat_i[5:0];
    end
  end

  // flag clear terms from software write-one and vector entry
  logic ext_clr;
  logic chg_clr;
  logic flag_wr;
  assign flag_wr = wr_hit(pinirq_pkg::IRQ_FLAG_OFS);
  assign ext_clr = (flag_wr && wb_dat_i[pinirq_pkg::EXT_BIT_POS]) ||
    taken_is(pinirq_pkg::VEC_EXT);
  assign chg_clr = (flag_wr && wb_dat_i[pinirq_pkg::CHG_BIT_POS]) ||
    taken_is(pinirq_pkg::VEC_CHANGE);

  // external flag: a new event beats a clear in the same cycle
  // level mode wins over everything: the flag must read zero there
  // set on edge, clear on one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_r[1] <= pinirq_pkg::IRQ_FLAG_RST[6];
    end else if (level_mode) begin
      irq_flag_r[1] <= 1'b0;
    end else if (ext_edge_ev) begin
      irq_flag_r[1] <= 1'b1;
    end else if (ext_clr) begin
      irq_flag_r[1] <= 1'b0;
    end
  end

  // set wins over clear so a toggle during a clear is not lost
  // change flag set/clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_r[0] <= pinirq_pkg::IRQ_FLAG_RST[5];
    end else if (chg_ev) begin
      irq_flag_r[0] <= 1'b1;
    end else if (chg_clr) begin
      irq_flag_r[0] <= 1'b0;
    end
  end

  // external source: latched edge flag or the live low level
  logic ext_src;
  logic chg_src;
  assign ext_src = irq_flag_r[1] || ext_level_req;
  assign chg_src = irq_flag_r[0];

  // pending requests in vector order, index 0 = external pin
  // internal sources only need the global enable here
  logic [NS-1:0] pend;
  assign pend[0] = global_irq_en_i && irq_mask_r[1] && ext_src;
  assign pend[1] = global_irq_en_i && irq_mask_r[0] && chg_src;
  assign pend[NS-1:2] = global_irq_en_i ? internal_req_i : 7'h00;

  logic win_any;
  logic [3:0] win_idx;
  // a fixed order keeps the choice stable while requests change
  // lowest vector first
  pinirq_prio #(
    .N(NS)
  ) u_prio (
    .req_i(pend),
    .any_o(win_any),
    .idx_o(win_idx)
  );

  // next vector: the winner's index shifted past the reset word;
  // the reset word doubles as nothing pending
  logic [3:0] irq_vec_nxt;
  always_comb begin
    irq_vec_nxt = pinirq_pkg::VEC_RESET;
    if (win_any) begin
      irq_vec_nxt = win_idx + pinirq_pkg::VEC_EXT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_r <= 1'b0;
      irq_vec_r <= pinirq_pkg::VEC_RESET;
    end else if (irq_taken_i) begin
      irq_req_r <= 1'b0;
    end else begin
      irq_req_r <= win_any;
      irq_vec_r <= irq_vec_nxt;
    end
  end

  // core_reset_i covers every reset source, not only rst_i
  // fetch zero after reset
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_i) begin
      fetch_r <= pinirq_pkg::VEC_RESET;
    end else if (irq_taken_i) begin
      fetch_r <= irq_vec_r;
    end
  end

  // wake on a masked low level or masked pin toggle, even a low too short to dispatch;
  // then the core simply resumes after its sleep instruction
  // wake without interrupt
  logic wake_ext;
  logic wake_chg;
  logic wake_any;
  // wake sources kept apart: a pin low, a masked toggle, a request
  assign wake_ext = irq_mask_r[1] && ext_level_req;
  assign wake_chg = irq_mask_r[0] && chg_ev;
  assign wake_any = wake_ext || wake_chg || win_any;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= sleeping_i && wake_any;
    end
  end

  // read mux, decoded from the address the master holds
  // reserved bits zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i)
      pinirq_pkg::SENSE_CTRL_OFS: rd_byte = {6'h00, sense_r};
      pinirq_pkg::IRQ_MASK_OFS: rd_byte = {1'b0, irq_mask_r, 5'h00};
      pinirq_pkg::IRQ_FLAG_OFS: rd_byte = {1'b0, irq_flag_r, 5'h00};
      pinirq_pkg::CHANGE_MASK_OFS: rd_byte = {2'h0, change_mask_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // single-wait ack; unmapped addresses ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= bus_new;
    end
  end

  // read data registered with the ack so it stands in the ack cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_dat_r <= {24'h000000, rd_byte & rd_keep(wb_adr_i)};
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign irq_req_o = irq_req_r;
  assign irq_vec_o = irq_vec_r;
  assign wake_o = wake_r;
  assign fetch_addr_o = fetch_r;
endmodule

// ### shared/pinirq_pkg.sv
package pinirq_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [3:0] SENSE_CTRL_OFS = 4'h0;
  localparam logic [3:0] IRQ_MASK_OFS = 4'h4;
  localparam logic [3:0] IRQ_FLAG_OFS = 4'h8;
  localparam logic [3:0] CHANGE_MASK_OFS = 4'hC;
  // field positions
  localparam int SENSE_LO_POS = 0;
  localparam int SENSE_HI_POS = 1;
  localparam int EXT_BIT_POS = 6;
  localparam int CHG_BIT_POS = 5;
  // reset values
  localparam logic [7:0] SENSE_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAG_RST = 8'h00;
  localparam logic [5:0] CHANGE_MASK_RST = 6'h00;
  // writable bits of the mask and flag registers
  localparam logic [7:0] IRQ_BITS_MASK = 8'h60;
  // sense modes
  typedef enum logic [1:0] {
    PINIRQ_LOW = 2'h0,
    PINIRQ_ANY = 2'h1,
    PINIRQ_FALL = 2'h2,
    PINIRQ_RISE = 2'h3
  } pinirq_sense_type;
  // vector word addresses
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_EXT = 4'h1;
  localparam logic [3:0] VEC_CHANGE = 4'h2;
  localparam logic [3:0] VEC_TIMER_OVF = 4'h3;
  localparam logic [3:0] VEC_EEPROM = 4'h4;
  localparam logic [3:0] VEC_COMPARATOR = 4'h5;
  localparam logic [3:0] VEC_COMPARE_A = 4'h6;
  localparam logic [3:0] VEC_COMPARE_B = 4'h7;
  localparam logic [3:0] VEC_WATCHDOG = 4'h8;
  localparam logic [3:0] VEC_CONVERTER = 4'h9;
  localparam int NUM_SOURCES = 9;
endpackage

// ### verilog/pinirq_prio.sv
`timescale 1ns/1ps
// fixed priority pick: lowest source index wins
module pinirq_prio #(
  parameter int N = 9
) (
  input wire logic [N-1:0] req_i, // pending enabled requests
  output logic any_o, // some request pending
  output logic [3:0] idx_o // index of winning source
);
  // elaboration check: the index port is only four bits wide
  if (N < 1 || N > 15) begin : g_bad_n
    $error("pinirq_prio: N out of range");
  end

  // scan from the top down so the lowest index is kept last
  always_comb begin
    any_o = 1'b0;
    idx_o = 4'h0;
    for (int k = N - 1; k >= 0; k--) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        idx_o = 4'(k);
      end
    end
  end
endmodule

// ### testbench/pinirq_props.sv
`timescale 1ns/1ps
// bus and dispatch checks on the controller ports
module pinirq_props (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [3:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic global_irq_en_i, // global enable
  input wire logic core_reset_i, // reset source
  input wire logic [6:0] internal_req_i, // internal requests
  input wire logic irq_taken_i, // vector entry
  input wire logic irq_req_o, // request
  input wire logic [3:0] irq_vec_o, // vector
  input wire logic [3:0] fetch_addr_o // fetch word
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // an unanswered request, then its answer
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a: assert property (bus_req_s |=> ack_s)
    else $error("ack not a one cycle answer");
  reserved_zero_a: assert property (wb_ack_o && wb_adr_i[3] != wb_adr_i[2]
    |-> (wb_dat_o & 32'hFFFFFF9F) == 32'h0) else $error("reserved bit set");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_fetch_a: assert property (core_reset_i |=> fetch_addr_o == 4'h0)
    else $error("reset fetch not zero");
  taken_fetch_a: assert property (irq_taken_i && !core_reset_i
    |=> fetch_addr_o == $past(irq_vec_o)) else $error("fetch not vector");
  vec_range_a: assert property (irq_req_o |-> irq_vec_o inside {[1:9]})
    else $error("vector out of range");
  global_gate_a: assert property (!global_irq_en_i |=> !irq_req_o)
    else $error("request without global enable");
  prio_pick_a: assert property (global_irq_en_i && internal_req_i[0]
    && !irq_taken_i && !$past(irq_taken_i) |=> irq_req_o && irq_vec_o <= 4'h3)
    else $error("timer request lost priority");
endmodule

bind pinirq_ctrl pinirq_props i_pinirq_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .global_irq_en_i(global_irq_en_i), .core_reset_i(core_reset_i),
  .internal_req_i(internal_req_i), .irq_taken_i(irq_taken_i),
  .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o),
  .fetch_addr_o(fetch_addr_o));

// ### testbench/pinirq_core_model.sv
`timescale 1ns/1ps
// core dispatch: enters a pending vector promptly or late
module pinirq_core_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic irq_req_i, // request from controller
  input wire logic slow_i, // take requests late
  output logic taken_o // vector entry pulse
);
  logic [1:0] wait_r;
  // one pulse per request; restart so a cleared request is never taken
  always_ff @(posedge clk_i) begin
    if (rst_i || taken_o || !irq_req_i) begin
      wait_r <= 2'h0;
      taken_o <= 1'b0;
    end else if (wait_r == (slow_i ? 2'h3 : 2'h0)) begin
      taken_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// ### testbench/pin_interrupt_controller_test.sv
`timescale 1ns/1ps
module pin_interrupt_controller_test;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pin = 1'b1;
  logic gie = 1'b0, slp = 1'b0, crst = 1'b0, slow = 1'b0, seen;
  logic taken, ack, req, wake, ioclk = 1'b1;
  logic [3:0] adr = 4'h0, vec, fetch;
  logic [5:0] chg = 6'h00, mk;
  logic [6:0] ireq = 7'h00;
  logic [31:0] wdat = 32'h0, rdat, got, seed = 32'hA03A, r;
  int errors = 0, n_checks = 0, cycles = 0, k;
  always #12.5 clk_i = ~clk_i;
  pinirq_ctrl i_pinirq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin_i(pin),
    .change_inputs_i(chg), .global_irq_en_i(gie), .io_clk_run_i(ioclk),
    .sleeping_i(slp), .core_reset_i(crst), .internal_req_i(ireq),
    .irq_taken_i(taken), .irq_req_o(req), .irq_vec_o(vec), .wake_o(wake),
    .fetch_addr_o(fetch));
  pinirq_core_model i_pinirq_core_model (.clk_i(clk_i), .rst_i(rst_i),
    .irq_req_i(req), .slow_i(slow), .taken_o(taken));
  // hang guard, far above the run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic cycle held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(got, e);
  endtask
  task automatic wait_fetch(input logic [3:0] e);
    for (int n = 0; n < 20 && fetch !== e; n++) tick(1);
    check({28'h0, fetch}, {28'h0, e});
  endtask
  function automatic logic exp_edge(input int m, input logic s);
    return m == 1 || (m == 2 && s) || (m == 3 && !s);
  endfunction
  function automatic logic [3:0] exp_vec(input logic [6:0] q);
    for (int i = 0; i < 7; i++) if (q[i]) return 4'(i + 3);
    return 4'h0;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // main sequence: registers, sense modes, changes, dispatch, wake
  initial begin
    tick(2);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) rd(4'(a * 4), 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, pinirq_pkg::IRQ_MASK_OFS, 8'hFF);
    rd(pinirq_pkg::IRQ_MASK_OFS, 32'h60);
    bus(1'b1, pinirq_pkg::CHANGE_MASK_OFS, 8'hFF);
    rd(pinirq_pkg::CHANGE_MASK_OFS, 32'h3F);
    pin <= 1'b0;
    tick(4);
    rd(pinirq_pkg::IRQ_FLAG_OFS, 32'h0);
    for (int m = 1; m < 4; m++) for (int s = 0; s < 2; s++) begin
      bus(1'b1, pinirq_pkg::SENSE_CTRL_OFS, 8'(m));
      pin <= s[0];
      tick(4);
      bus(1'b1, pinirq_pkg::IRQ_FLAG_OFS, 8'h60);
      pin <= !s[0];
      tick(4);
      rd(pinirq_pkg::IRQ_FLAG_OFS, {25'h0, exp_edge(m, s[0]), 6'h0});
    end
    // a pulse while the I/O clock is stopped leaves no flag
    bus(1'b1, pinirq_pkg::IRQ_FLAG_OFS, 8'h60);
    ioclk <= 1'b0;
    pin <= 1'b1;
    tick(4);
    pin <= 1'b0;
    tick(2);
    ioclk <= 1'b1;
    tick(4);
    rd(pinirq_pkg::IRQ_FLAG_OFS, 32'h0);
    repeat (8) begin
      r = rnd();
      k = int'(r[15:8]) % 6;
      mk = r[5:0];
      bus(1'b1, pinirq_pkg::CHANGE_MASK_OFS, {2'h0, mk});
      bus(1'b1, pinirq_pkg::IRQ_FLAG_OFS, 8'h60);
      chg <= chg ^ (6'h01 << k);
      tick(3);
      rd(pinirq_pkg::IRQ_FLAG_OFS, {26'h0, mk[k], 5'h0});
    end
    bus(1'b1, pinirq_pkg::CHANGE_MASK_OFS, 8'h00);
    bus(1'b1, pinirq_pkg::SENSE_CTRL_OFS, 8'h00);
    bus(1'b1, pinirq_pkg::IRQ_FLAG_OFS, 8'h60);
    // pin held low until the vector is entered
    gie <= 1'b1;
    pin <= 1'b0;
    wait_fetch(pinirq_pkg::VEC_EXT);
    pin <= 1'b1;
    repeat (8) begin
      r = rnd();
      slow <= r[7];
      crst <= 1'b1;
      tick(1);
      crst <= 1'b0;
      tick(1);
      check({28'h0, fetch}, 32'h0);
      ireq <= r[6:0] | 7'h40;
      wait_fetch(exp_vec(r[6:0] | 7'h40));
      ireq <= 7'h00;
      tick(3);
    end
    gie <= 1'b0;
    slp <= 1'b1;
    bus(1'b1, pinirq_pkg::CHANGE_MASK_OFS, 8'h3F);
    chg <= ~chg;
    seen = 1'b0;
    repeat (6) begin
      tick(1);
      seen = seen | (wake === 1'b1);
    end
    check({31'h0, seen}, 32'h1);
    // a one-cycle low while asleep still wakes the core
    check({31'h0, wake}, 32'h0);
    seen = 1'b0;
    pin <= 1'b0;
    tick(1);
    pin <= 1'b1;
    repeat (3) begin
      tick(1);
      seen = seen | (wake === 1'b1);
    end
    check({31'h0, seen}, 32'h1);
    tally_and_finish();
  end
endmodule
